// ### hdl/otc_pkg.sv
package otc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int WINDOW_MS = 16;
    localparam int WINDOW_SAMPLES = SAMPLE_HZ * WINDOW_MS / 1000;

    // ****************************************
    // analysis bank
    // ****************************************
    localparam int NUM_TONES = 8;
    localparam int GROUP_SIZE = 4;
    localparam int IDX_W = 2;
    localparam int PHASE_W = 16;
    localparam int ENERGY_THRESHOLD = 20;
    localparam int TONE_HZ [NUM_TONES] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};
    localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;

    // rounded phase step per sample for a square reference at f_hz
    function automatic logic [PHASE_W-1:0] phase_step(input int f_hz);
        longint step;
        step = (longint'(f_hz) * 65536 + SAMPLE_HZ / 2) / SAMPLE_HZ;
        return step[PHASE_W-1:0];
    endfunction

    typedef enum logic [1:0] {
        OTC_IDLE = 2'b00,
        OTC_RUN = 2'b01,
        OTC_PUSH = 2'b10
    } otc_state_t;
endpackage

// ### hdl/otc_pair_buf.sv
`timescale 1ns/1ps
module otc_pair_buf #(
    parameter int WIDTH = 8
) (
    input logic ref_clk,
    input logic reset,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;
    logic head_vld_reg;
    logic tail_vld_reg;
    logic push;
    logic pop;

    // ready comes from the tail flag so a stall downstream never drops a word
    assign in_ready = ~tail_vld_reg;
    assign out_valid = head_vld_reg;
    assign out_data = head_reg;
    assign push = in_valid & ~tail_vld_reg;
    assign pop = head_vld_reg & out_ready;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            head_vld_reg <= 1'b0;
            tail_vld_reg <= 1'b0;
        end else if (pop) begin
            if (tail_vld_reg) begin
                head_reg <= tail_reg;
                tail_vld_reg <= 1'b0;
            end else if (push) begin
                head_reg <= in_data;
            end else begin
                head_vld_reg <= 1'b0;
            end
        end else if (push) begin
            if (!head_vld_reg) begin
                head_reg <= in_data;
                head_vld_reg <= 1'b1;
            end else begin
                tail_reg <= in_data;
                tail_vld_reg <= 1'b1;
            end
        end
    end
endmodule

// ### hdl/otc_correlator.sv
`timescale 1ns/1ps
// Function
// - The tone arrives already sliced to one bit and only that bit is sampled.
// - Each product of sample and reference is the XNOR of the two 0/1 bits.
// - At every sampling instant the input bit is compared with each square reference bit.
// - A match counts the counter up by one and a mismatch counts the same counter down by one.
// - A periodic tick at the sampling rate triggers each compare-and-update step.
// - Every analysis frequency has a sine-phase and a cosine-phase counter, both updated each sample.
// - At window end the energy is the unsigned sum of the magnitudes of the two counter values.
// - References exist for the eight nominal frequencies 697 to 1633 Hz, four per group.
// - Per group the largest energy is dominant and is accepted only above the threshold.
module otc_correlator
    import otc_pkg::*;
#(
    parameter int SAMPLE_DIV = otc_pkg::SAMPLE_DIV,
    parameter int WINDOW_SAMPLES = otc_pkg::WINDOW_SAMPLES,
    parameter int THRESHOLD = otc_pkg::ENERGY_THRESHOLD,
    parameter int CNT_W = $clog2(WINDOW_SAMPLES + 1) + 1
) (
    input logic ref_clk,
    input logic reset,
    input logic tone_bit,
    input logic window_start,
    output logic window_busy,
    output logic res_valid,
    input logic res_ready,
    output logic [otc_pkg::IDX_W-1:0] res_low_idx,
    output logic res_low_ok,
    output logic [CNT_W:0] res_low_energy,
    output logic [otc_pkg::IDX_W-1:0] res_high_idx,
    output logic res_high_ok,
    output logic [CNT_W:0] res_high_energy
);
    import otc_pkg::*;

    localparam int EN_W = CNT_W + 1;
    localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
    localparam int SMP_W = $clog2(WINDOW_SAMPLES + 1);
    localparam int RES_W = 2 * (IDX_W + 1 + EN_W);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
    localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(WINDOW_SAMPLES - 1);
    localparam logic [EN_W-1:0] THR = EN_W'(THRESHOLD);

    // ****************************************
    // sampling tick and window sequencing
    // ****************************************
    otc_state_t state_reg;
    logic [DIV_W-1:0] div_reg;
    logic [SMP_W-1:0] smp_reg;
    logic tick;
    logic clear;
    logic busy_reg;
    logic buf_in_ready;
    logic push;

    assign tick = (div_reg == DIV_LAST);
    assign push = (state_reg == OTC_PUSH) && buf_in_ready;
    // a finished result also opens the next window, so windows follow back to back
    assign clear = window_start || push;

    always_ff @(posedge ref_clk) begin
        if (reset || clear) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= OTC_IDLE;
            smp_reg <= '0;
        end else if (clear) begin
            state_reg <= OTC_RUN;
            smp_reg <= '0;
        end else begin
            case (state_reg)
                OTC_RUN: begin
                    if (tick) begin
                        smp_reg <= smp_reg + 1'b1;
                        if (smp_reg == SMP_LAST) begin
                            state_reg <= OTC_PUSH;
                        end
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= clear || (state_reg == OTC_RUN);
        end
    end

    assign window_busy = busy_reg;

    // ****************************************
    // reference bank and match counters
    // ****************************************
    logic step;
    logic [EN_W-1:0] energy [NUM_TONES];

    assign step = tick && (state_reg == OTC_RUN);

    for (genvar t = 0; t < NUM_TONES; t++) begin : g_tone
        localparam logic [PHASE_W-1:0] INC = phase_step(TONE_HZ[t]);
        logic [PHASE_W-1:0] phase_reg;
        logic signed [CNT_W-1:0] sin_reg;
        logic signed [CNT_W-1:0] cos_reg;
        logic sin_ref;
        logic cos_ref;
        logic sin_hit;
        logic cos_hit;
        logic [CNT_W-1:0] sin_mag;
        logic [CNT_W-1:0] cos_mag;

        assign sin_ref = ~phase_reg[PHASE_W-1];
        // cosine square leads the sine square by a quarter turn
        assign cos_ref = ~(phase_reg[PHASE_W-1] ^ phase_reg[PHASE_W-2]);
        assign sin_hit = ~(tone_bit ^ sin_ref);
        assign cos_hit = ~(tone_bit ^ cos_ref);

        always_ff @(posedge ref_clk) begin
            if (reset || clear) begin
                phase_reg <= PHASE_RESET;
            end else if (step) begin
                phase_reg <= phase_reg + INC;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset || clear) begin
                sin_reg <= '0;
                cos_reg <= '0;
            end else if (step) begin
                sin_reg <= sin_hit ? sin_reg + 1'b1 : sin_reg - 1'b1;
                cos_reg <= cos_hit ? cos_reg + 1'b1 : cos_reg - 1'b1;
            end
        end

        assign sin_mag = sin_reg[CNT_W-1] ? CNT_W'(-sin_reg) : CNT_W'(sin_reg);
        assign cos_mag = cos_reg[CNT_W-1] ? CNT_W'(-cos_reg) : CNT_W'(cos_reg);
        assign energy[t] = {1'b0, sin_mag} + {1'b0, cos_mag};
    end

    // ****************************************
    // dominant pick per group
    // ****************************************
    logic [IDX_W-1:0] low_idx;
    logic [IDX_W-1:0] high_idx;
    logic [EN_W-1:0] low_max;
    logic [EN_W-1:0] high_max;

    // ties keep the lower frequency
    always_comb begin
        low_idx = '0;
        high_idx = '0;
        low_max = energy[0];
        high_max = energy[GROUP_SIZE];
        for (int i = 1; i < GROUP_SIZE; i++) begin
            if (energy[i] > low_max) begin
                low_max = energy[i];
                low_idx = IDX_W'(i);
            end
            if (energy[GROUP_SIZE + i] > high_max) begin
                high_max = energy[GROUP_SIZE + i];
                high_idx = IDX_W'(i);
            end
        end
    end

    // ****************************************
    // result buffer
    // ****************************************
    logic [RES_W-1:0] res_word;
    logic [RES_W-1:0] out_word;

    assign res_word = {low_idx, (low_max > THR), low_max,
                       high_idx, (high_max > THR), high_max};

    otc_pair_buf #(
        .WIDTH(RES_W)
    ) u_buf (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(state_reg == OTC_PUSH),
        .in_ready(buf_in_ready),
        .in_data(res_word),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(out_word)
    );

    assign {res_low_idx, res_low_ok, res_low_energy,
            res_high_idx, res_high_ok, res_high_energy} = out_word;
endmodule

// ### test/otc_correlator_assertions.sv
`timescale 1ns/1ps
module otc_corr_chk
    import otc_pkg::*;
#(
    parameter int WINDOW_SAMPLES = 128,
    parameter int THRESHOLD = 20,
    parameter int CNT_W = 9
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tone_bit,
    input wire logic window_start,
    input wire logic window_busy,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [IDX_W-1:0] res_low_idx,
    input wire logic res_low_ok,
    input wire logic [CNT_W:0] res_low_energy,
    input wire logic [IDX_W-1:0] res_high_idx,
    input wire logic res_high_ok,
    input wire logic [CNT_W:0] res_high_energy
);
    // ****
    // result word and window checks
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_busy8;
        window_busy [*8];
    endsequence
    sequence s_held;
        res_valid && $stable(res_low_energy) && $stable(res_high_energy);
    endsequence
    property p_rst;
        disable iff (1'b0) reset |=> !res_valid && !window_busy;
    endproperty
    property p_busy;
        window_start |=> s_busy8;
    endproperty
    property p_hold;
        res_valid && !res_ready |=> s_held;
    endproperty
    property p_idx;
        res_valid && !res_ready |=> $stable(res_low_idx) && $stable(res_high_idx);
    endproperty
    property p_lok;
        res_valid |-> res_low_ok == (res_low_energy > THRESHOLD);
    endproperty
    property p_hok;
        res_valid |-> res_high_ok == (res_high_energy > THRESHOLD);
    endproperty
    property p_max;
        res_valid |-> res_low_energy <= 2 * WINDOW_SAMPLES && res_high_energy <= 2 * WINDOW_SAMPLES;
    endproperty
    // both counters step by one each sample, so the sum of magnitudes is always even
    property p_even;
        res_valid |-> !res_low_energy[0] && !res_high_energy[0];
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    a_busy: assert property (p_busy) else $error("window not sampling");
    a_hold: assert property (p_hold) else $error("result lost in stall");
    a_idx: assert property (p_idx) else $error("index moved in stall");
    a_lok: assert property (p_lok) else $error("low accept wrong");
    a_hok: assert property (p_hok) else $error("high accept wrong");
    a_max: assert property (p_max) else $error("energy too large");
    a_even: assert property (p_even) else $error("energy odd");
endmodule

// ### test/otc_tone_src.sv
`timescale 1ns/1ps
module otc_tone_src #(
    parameter int DIV = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic window_start,
    input wire logic [15:0] step,
    input wire logic flip,
    output logic tone_bit
);
    // ****
    // sliced tone, edges kept midway between ticks so sampling never races
    // ****
    int cnt;
    logic [15:0] ph;
    always_ff @(posedge ref_clk) begin
        if (reset || window_start) begin
            cnt <= 0;
            ph <= 16'h0000;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            if (cnt == DIV / 2) begin
                ph <= ph + step;
                tone_bit <= ph[15] ^ flip;
            end
        end
        if (reset) tone_bit <= 1'b0;
    end
endmodule

// ### test/otc_correlator_bench.sv
`timescale 1ns/1ps
module otc_correlator_bench;
    import otc_pkg::*;
    // ****
    // stimulus, model and checks
    // ****
    localparam int DIV = 8;
    localparam int WS = 16;
    localparam int TH = 20;
    localparam int CW = $clog2(WS + 1) + 1;
    logic ref_clk = 0;
    logic reset = 1;
    logic window_start = 0;
    logic res_ready = 0;
    logic flip = 0;
    logic noisy = 0;
    logic [15:0] step = 16'h0000;
    logic [31:0] rnd = 32'hfe1b;
    logic tone_bit, window_busy, res_valid, res_low_ok, res_high_ok;
    logic [IDX_W-1:0] res_low_idx, res_high_idx;
    logic [CW:0] res_low_energy, res_high_energy;
    logic bits[$];
    int expv[6];
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    otc_correlator #(.SAMPLE_DIV(DIV), .WINDOW_SAMPLES(WS), .THRESHOLD(TH)) DUT (.*);
    otc_tone_src #(.DIV(DIV)) src (.*);
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] stp(int f);
        return 16'((f * 65536 + SAMPLE_HZ / 2) / SAMPLE_HZ);
    endfunction
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        rnd <= lfsr(rnd);
        flip <= noisy & rnd[7];
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(string n, int e, logic [CW:0] g);
        compares++;
        if (g !== (CW + 1)'(e)) begin
            fails++;
            $display("MISMATCH %s exp %0d got %0d", n, e, g);
        end
    endtask
    task automatic model();
        int e[8];
        int s, c, b;
        logic [15:0] ph;
        for (int i = 0; i < 8; i++) begin
            ph = 16'h0000;
            s = 0;
            c = 0;
            foreach (bits[n]) begin
                s += (bits[n] == !ph[15]) ? 1 : -1;
                c += (bits[n] == !(ph[15] ^ ph[14])) ? 1 : -1;
                ph += stp(TONE_HZ[i]);
            end
            e[i] = (s < 0 ? -s : s) + (c < 0 ? -c : c);
        end
        for (int g = 0; g < 2; g++) begin
            b = 0;
            for (int k = 1; k < 4; k++) if (e[4 * g + k] > e[4 * g + b]) b = k;
            expv[3 * g] = b;
            expv[3 * g + 1] = e[4 * g + b] > TH;
            expv[3 * g + 2] = e[4 * g + b];
        end
    endtask
    task automatic pulse();
        @(posedge ref_clk) window_start <= 1'b1;
        @(posedge ref_clk) window_start <= 1'b0;
    endtask
    task automatic get_res();
        for (int t = 0; t < 24 && res_valid !== 1'b1; t++) begin
            @(posedge ref_clk);
            #1;
        end
        cmp("valid", 1, res_valid);
        cmp("low_idx", expv[0], res_low_idx);
        cmp("low_ok", expv[1], res_low_ok);
        cmp("low_energy", expv[2], res_low_energy);
        cmp("high_idx", expv[3], res_high_idx);
        cmp("high_ok", expv[4], res_high_ok);
        cmp("high_energy", expv[5], res_high_energy);
        @(posedge ref_clk) res_ready <= 1'b1;
        @(posedge ref_clk) res_ready <= 1'b0;
        #1;
    endtask
    // second start lands mid-window, so only the restarted window may count
    task automatic run_win(logic [15:0] st);
        @(posedge ref_clk) step <= st;
        pulse();
        repeat (rnd[4:0]) @(posedge ref_clk);
        pulse();
        #1 cmp("busy", 1, window_busy);
        bits.delete();
        repeat (WS) begin
            repeat (DIV) @(posedge ref_clk);
            #1 bits.push_back(tone_bit);
        end
        model();
        get_res();
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        #1 cmp("idle_busy", 0, window_busy);
        cmp("idle_valid", 0, res_valid);
        for (int i = 0; i < NUM_TONES; i++) run_win(stp(TONE_HZ[i]));
        noisy = 1'b1;
        repeat (3) run_win(rnd[15:0]);
        noisy = 1'b0;
        run_win(16'h0000);
        // steady input lets later self-started windows be predicted too
        pulse();
        repeat (3 * (WS * DIV + 2) + 16) @(posedge ref_clk);
        #1;
        repeat (3) get_res();
        stop_test();
    end
endmodule
bind otc_correlator otc_corr_chk #(
    .WINDOW_SAMPLES(WINDOW_SAMPLES),
    .THRESHOLD(THRESHOLD),
    .CNT_W(CNT_W)
) chk (.*);
